//--- hdl/asq_cfg_if.sv
// Carries the stored step 4 fields to the decoders and their results back.
// Assumes the owner drives cfg and each decoder drives only its results.
`default_nettype none

interface asq_cfg_if;
    import asq_pkg::*;

    asq_cfg_t   cfg;          // Stored register fields.
    logic [2:0] gain_factor;  // Gain as a factor of 1, 2 or 4.
    logic [7:0] ext_onehot;   // One-hot external positive input.
    asq_src_t   src;          // Positive input source.
    logic       neg_auto;     // Negative input chosen by hardware.
    logic       neg_gnd;      // Negative input on analog ground.
    logic       neg_ext7;     // Negative input on external input seven.

    modport owner (output cfg, input gain_factor, ext_onehot, src,
                   neg_auto, neg_gnd, neg_ext7);
    modport input_dec (input cfg, output ext_onehot, src, neg_auto,
                       neg_gnd, neg_ext7);
    modport gain_dec (input cfg, output gain_factor);
endinterface

`default_nettype wire

//--- hdl/asq_gain_decode.sv
// Turns the stored two-bit gain code into a gain factor.
// Assumes the owner of the interface holds the code stable in a register.
`default_nettype none

module asq_gain_decode (
    asq_cfg_if.gain_dec bus  // Stored fields in, gain factor out.
);
    import asq_pkg::*;

    // Both upper codes give the highest gain, so only bit 1 matters there.
    always_comb begin
        case (bus.cfg.gain)
            GAIN_CODE_X1: bus.gain_factor = GAIN_FACTOR_X1; // see [R2]
            GAIN_CODE_X2: bus.gain_factor = GAIN_FACTOR_X2; // see [R2]
            default:      bus.gain_factor = GAIN_FACTOR_X4; // see [R2]
        endcase
    end
endmodule

`default_nettype wire

//--- hdl/asq_input_decode.sv
// Decodes the positive and negative input selects into multiplexer controls.
// Assumes the owner of the interface holds the fields stable in a register.
`default_nettype none

module asq_input_decode (
    asq_cfg_if.input_dec bus  // Stored fields in, mux controls out.
);
    import asq_pkg::*;

    // Internal sources pick their own negative input, so they set neg_auto.
    always_comb begin
        bus.ext_onehot = 8'h00;
        bus.src        = SRC_EXTERNAL;
        bus.neg_auto   = 1'b1;
        case (bus.cfg.pos)
            POS_TEMP:   bus.src = SRC_TEMP_SENSOR;        // see [R5]
            POS_SHORT:  bus.src = SRC_INT_SHORT;          // see [R5]
            POS_TDAC:   bus.src = SRC_TEST_DAC;           // see [R5]
            POS_AVDD4:  bus.src = SRC_ANALOG_SUPPLY_DIV4; // see [R9]
            POS_IO_MON: bus.src = SRC_IO_SUPPLY_MON;      // see [R11]
            POS_DCORE:  bus.src = SRC_DCORE_SUPPLY_MON;   // see [R11]
            POS_ANALOG_POWER_INPUT:   bus.src = SRC_ANALOG_PWR_DIV103;  // see [R6]
            POS_DIGITAL_POWER_INPUT:   bus.src = SRC_DIGITAL_PWR_DIV103; // see [R6]
            default: begin
                // Only codes 0 to 7 remain here, all external inputs.
                bus.ext_onehot = 8'h01 << bus.cfg.pos[2:0]; // see [R4]
                bus.neg_auto   = 1'b0;
            end
        endcase
        // The negative select is honoured only for external inputs.
        bus.neg_gnd  = ~bus.neg_auto & ~bus.cfg.neg; // see [R3] [R7]
        bus.neg_ext7 = ~bus.neg_auto & bus.cfg.neg;  // see [R3] [R7]
    end
endmodule

`default_nettype wire

//--- hdl/asq_pkg.sv
// Shared constants and types for the auxiliary sequencer step 4 block.
// Assumes one clock domain and an APB slave with 32-bit data.
`default_nettype none

package asq_pkg;

    // Bus and register geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] STEP4_CFG_ADDR  = 12'h094;
    localparam logic [15:0]       STEP4_CFG_RESET = 16'h0004;

    // Field positions inside the 16-bit register word.
    localparam int EN_BIT  = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int RSV_HI  = 12;
    localparam int RSV_LO  = 5;
    localparam int NEG_BIT = 4;
    localparam int POS_HI  = 3;
    localparam int POS_LO  = 0;

    // Gain codes and the factor that each one yields.
    localparam logic [1:0] GAIN_CODE_X1   = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2   = 2'h1;
    localparam logic [2:0] GAIN_FACTOR_X1 = 3'h1;
    localparam logic [2:0] GAIN_FACTOR_X2 = 3'h2;
    localparam logic [2:0] GAIN_FACTOR_X4 = 3'h4;

    // Positive-input codes; codes up to POS_EXT_LAST are external inputs.
    localparam logic [3:0] POS_EXT_LAST = 4'h7;
    localparam logic [3:0] POS_TEMP     = 4'h8;
    localparam logic [3:0] POS_SHORT    = 4'h9;
    localparam logic [3:0] POS_TDAC     = 4'ha;
    localparam logic [3:0] POS_AVDD4    = 4'hb;
    localparam logic [3:0] POS_IO_MON   = 4'hc;
    localparam logic [3:0] POS_DCORE    = 4'hd;
    localparam logic [3:0] POS_ANALOG_POWER_INPUT     = 4'he;
    localparam logic [3:0] POS_DIGITAL_POWER_INPUT     = 4'hf;

    // Source that feeds the positive converter input.
    typedef enum logic [3:0] {
        SRC_EXTERNAL,
        SRC_TEMP_SENSOR,
        SRC_INT_SHORT,
        SRC_TEST_DAC,
        SRC_ANALOG_SUPPLY_DIV4,
        SRC_IO_SUPPLY_MON,
        SRC_DCORE_SUPPLY_MON,
        SRC_ANALOG_PWR_DIV103,
        SRC_DIGITAL_PWR_DIV103
    } asq_src_t;

    // Writable fields of the register, reserved bits left out.
    typedef struct packed {
        logic       en;
        logic [1:0] gain;
        logic       neg;
        logic [3:0] pos;
    } asq_cfg_t;

    localparam asq_cfg_t CFG_RESET_FIELDS = {
        STEP4_CFG_RESET[EN_BIT:GAIN_LO], STEP4_CFG_RESET[NEG_BIT:POS_LO]};

    // Decoded output values that match the register reset value.
    localparam logic [7:0] RST_EXT_ONEHOT = 8'h10;

endpackage

`default_nettype wire

//--- hdl/asq_step4_top.sv
// Step 4 configuration register of the auxiliary converter sequencer,
// reached over APB, with registered decoded controls for the sequencer.
// Assumes an APB master on REF_CLK_I and a sequencer that samples outputs.
//
// Notes on behaviour
// [R1] Step 4 takes part in the sequence only while the enable bit 15 is 1.
// [R2] Gain bits 14:13 give gain 1 for 00b, 2 for 01b and 4 otherwise.
// [R3] Bit 4 picks analog ground when 0 and external input seven when 1.
// [R4] Positive codes 0000b to 0111b pick external inputs zero to seven.
// [R5] Codes 1000b, 1001b, 1010b pick temperature, short and test DAC.
// [R6] Codes 1110b and 1111b pick the power-input monitors divided by 103.
// [R7] Whenever hardware picks the negative input, bit 4 is ignored.
// [R8] The register sits at address 94h and resets to 0004h.
// [R9] Code 1011b picks the analog supply divided by four.
// [R10] Bits 12:5 read as zero and ignore what is written to them.
// [R11] Codes 1100b and 1101b pick the io and core supply monitors.
`default_nettype none

module asq_step4_top
    import asq_pkg::*;
(
    input  wire logic                  REF_CLK_I,       // 25 MHz clock.
    input  wire logic                  RESETN_I,        // Async reset, low.
    input  wire logic                  PSEL_I,          // APB select.
    input  wire logic                  PENABLE_I,       // APB enable.
    input  wire logic                  PWRITE_I,        // APB direction.
    input  wire logic [asq_pkg::ADDR_W-1:0] PADDR_I,    // APB byte address.
    input  wire logic [asq_pkg::DATA_W-1:0] PWDATA_I,   // APB write data.
    input  wire logic [3:0]            PSTRB_I,         // APB byte strobes.
    output logic [asq_pkg::DATA_W-1:0] PRDATA_O,        // APB read data.
    output logic                       PREADY_O,        // APB ready.
    output logic                       PSLVERR_O,       // Unmapped address.
    output logic                       STEP4_ENABLE_O,  // Step included.
    output logic [2:0]                 STEP4_GAIN_O,    // Gain 1, 2 or 4.
    output logic [7:0]                 STEP4_EXT_POS_O, // One-hot ext input.
    output var asq_pkg::asq_src_t      STEP4_SRC_O,     // Positive source.
    output logic                       STEP4_NEG_AUTO_O, // Negative by hw.
    output logic                       STEP4_NEG_GND_O, // Negative on ground.
    output logic                       STEP4_NEG_EXT7_O // Negative on input 7.
);
    import asq_pkg::*;

    // Every flip-flop of the block lives in this one record.
    typedef struct packed {
        asq_cfg_t          cfg;
        logic              untouched;
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
        logic              out_enable;
        logic [2:0]        out_gain;
        logic [7:0]        out_ext;
        asq_src_t          out_src;
        logic              out_neg_auto;
        logic              out_neg_gnd;
        logic              out_neg_ext7;
    } asq_top_state_t;

    localparam asq_top_state_t STATE_RESET = '{
        cfg:          CFG_RESET_FIELDS,
        untouched:    1'b1,
        prdata:       32'h0000_0000,
        pready:       1'b0,
        pslverr:      1'b0,
        out_enable:   CFG_RESET_FIELDS.en,
        out_gain:     GAIN_FACTOR_X1,
        out_ext:      RST_EXT_ONEHOT,
        out_src:      SRC_EXTERNAL,
        out_neg_auto: 1'b0,
        out_neg_gnd:  1'b1,
        out_neg_ext7: 1'b0
    };

    asq_top_state_t st;
    asq_top_state_t next_st;
    asq_cfg_if      cfg_bus ();

    logic        setup;
    logic        access;
    logic        hit;
    logic        wr_hit;
    logic        rd_hit;
    logic [15:0] cfg_word;

    // Bus phase decode; the access phase lasts exactly one cycle.
    assign setup  = PSEL_I & ~PENABLE_I;
    assign access = PSEL_I & PENABLE_I & st.pready;
    assign hit    = (PADDR_I == STEP4_CFG_ADDR);       // see [R8]
    assign wr_hit = access & PWRITE_I & hit;
    assign rd_hit = access & ~PWRITE_I & hit;

    // Reserved bits are forced to zero on readback.
    assign cfg_word = {st.cfg.en, st.cfg.gain, 8'h00,
                       st.cfg.neg, st.cfg.pos};       // see [R10]

    assign cfg_bus.cfg = st.cfg;

    asq_gain_decode u_gain_decode (
        .bus (cfg_bus.gain_dec)
    );

    asq_input_decode u_input_decode (
        .bus (cfg_bus.input_dec)
    );

    // Next state: bus answer, register update and registered controls.
    always_comb begin
        next_st        = st;
        // Ready is raised for the access phase that follows each setup.
        next_st.pready = setup;
        // Error follows ready, so a transfer that is dropped leaves none.
        next_st.pslverr = setup & ~hit;
        if (setup) begin
            next_st.prdata = hit ? {16'h0000, cfg_word} : 32'h0000_0000;
        end
        if (wr_hit) begin
            // Byte lanes: lane 0 holds the selects, lane 1 enable and gain.
            if (PSTRB_I[0]) begin
                next_st.cfg.neg = PWDATA_I[NEG_BIT];          // see [R3]
                next_st.cfg.pos = PWDATA_I[POS_HI:POS_LO];    // see [R4]
            end
            if (PSTRB_I[1]) begin
                next_st.cfg.en   = PWDATA_I[EN_BIT];          // see [R1]
                next_st.cfg.gain = PWDATA_I[GAIN_HI:GAIN_LO]; // see [R2]
            end
            next_st.untouched = 1'b0;
        end
        // Controls lag the register by one cycle so outputs are flops.
        next_st.out_enable   = st.cfg.en;                     // see [R1]
        next_st.out_gain     = cfg_bus.gain_factor;           // see [R2]
        next_st.out_ext      = cfg_bus.ext_onehot;            // see [R4]
        next_st.out_src      = cfg_bus.src;                   // see [R5]
        next_st.out_neg_auto = cfg_bus.neg_auto;              // see [R7]
        next_st.out_neg_gnd  = cfg_bus.neg_gnd;               // see [R3]
        next_st.out_neg_ext7 = cfg_bus.neg_ext7;              // see [R3]
    end

    // State register.
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st <= STATE_RESET;                                // see [R8]
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state record.
    assign PRDATA_O         = st.prdata;
    assign PREADY_O         = st.pready;
    assign PSLVERR_O        = st.pslverr;
    assign STEP4_ENABLE_O   = st.out_enable;
    assign STEP4_GAIN_O     = st.out_gain;
    assign STEP4_EXT_POS_O  = st.out_ext;
    assign STEP4_SRC_O      = st.out_src;
    assign STEP4_NEG_AUTO_O = st.out_neg_auto;
    assign STEP4_NEG_GND_O  = st.out_neg_gnd;
    assign STEP4_NEG_EXT7_O = st.out_neg_ext7;

    // Checks of the decoded controls against the stored fields, plus the reset word, unmapped error and reserved-bit readback.
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    AST_ENABLE_FOLLOWS_WRITE: // see [R1]
    assert property (wr_hit && PSTRB_I[1] |=> ##1
        STEP4_ENABLE_O == $past(PWDATA_I[EN_BIT], 2))
    else $error("Step enable does not follow the written bit.");

    AST_GAIN_HIGH_CODES: // see [R2]
    assert property (st.cfg.gain[1] |=> STEP4_GAIN_O == GAIN_FACTOR_X4)
    else $error("Upper gain codes must give gain four.");

    AST_GAIN_LOW_CODES: // see [R2]
    assert property (!st.cfg.gain[1] |=> STEP4_GAIN_O ==
        ($past(st.cfg.gain[0]) ? GAIN_FACTOR_X2 : GAIN_FACTOR_X1))
    else $error("Lower gain codes must give gain one or two.");

    AST_NEG_SELECT: // see [R3]
    assert property (st.cfg.pos <= POS_EXT_LAST |=>
        STEP4_NEG_EXT7_O == $past(st.cfg.neg) &&
        STEP4_NEG_GND_O == !$past(st.cfg.neg))
    else $error("Negative select not honoured for an external input.");

    AST_EXT_ONEHOT: // see [R4]
    assert property (st.cfg.pos <= POS_EXT_LAST |=>
        STEP4_EXT_POS_O == (8'h01 << $past(st.cfg.pos[2:0])) &&
        STEP4_SRC_O == SRC_EXTERNAL)
    else $error("External positive input decoded wrongly.");

    AST_INTERNAL_SOURCES: // see [R5]
    assert property (st.cfg.pos == POS_TEMP || st.cfg.pos == POS_SHORT |=>
        STEP4_SRC_O == ($past(st.cfg.pos[0]) ? SRC_INT_SHORT
                                             : SRC_TEMP_SENSOR))
    else $error("Temperature or short source decoded wrongly.");

    AST_TEST_DAC: // see [R5]
    assert property (st.cfg.pos == POS_TDAC |=>
        STEP4_SRC_O == SRC_TEST_DAC && STEP4_EXT_POS_O == 8'h00)
    else $error("Test source decoded wrongly.");

    AST_POWER_MONITORS: // see [R6]
    assert property (st.cfg.pos[3:1] == POS_ANALOG_POWER_INPUT[3:1] |=> STEP4_SRC_O ==
        ($past(st.cfg.pos[0]) ? SRC_DIGITAL_PWR_DIV103
                              : SRC_ANALOG_PWR_DIV103))
    else $error("Power-input monitor decoded wrongly.");

    AST_NEG_IGNORED: // see [R7]
    assert property (st.cfg.pos > POS_EXT_LAST |=> STEP4_NEG_AUTO_O &&
        !STEP4_NEG_GND_O && !STEP4_NEG_EXT7_O)
    else $error("Negative select must be ignored for internal sources.");

    AST_RESET_VALUE: // see [R8]
    assert property (st.untouched |-> cfg_word == STEP4_CFG_RESET)
    else $error("Register left its reset value without a write.");

    AST_UNMAPPED_ERROR: // see [R8]
    assert property (setup && !hit |=> PREADY_O && PSLVERR_O &&
        PRDATA_O == 32'h0000_0000 ##1 !PREADY_O && !PSLVERR_O)
    else $error("Unmapped access must end in an error answer.");

    AST_RESERVED_ZERO: // see [R10]
    assert property (rd_hit |-> PRDATA_O[31:RSV_LO] ==
        {16'h0000, PRDATA_O[EN_BIT:GAIN_LO], 8'h00} && !PSLVERR_O)
    else $error("Reserved bits must read as zero.");

    AST_SUPPLY_DIV4: // see [R9]
    assert property (st.cfg.pos == POS_AVDD4 |=>
        STEP4_SRC_O == SRC_ANALOG_SUPPLY_DIV4 && STEP4_NEG_AUTO_O)
    else $error("Analog supply divider decoded wrongly.");

    AST_SUPPLY_MONITORS: // see [R11]
    assert property (st.cfg.pos[3:1] == POS_IO_MON[3:1] |=>
        STEP4_NEG_AUTO_O && STEP4_SRC_O == ($past(st.cfg.pos[0]) ?
        SRC_DCORE_SUPPLY_MON : SRC_IO_SUPPLY_MON))
    else $error("Supply monitor codes decoded wrongly.");

    // Bus answer checks; ready held too long would hand the master a stale
    // word on the next transfer, so it must last one cycle only.
    AST_READY_ONE_CYCLE: // see [R8]
    assert property (PREADY_O |=> !PREADY_O)
    else $error("Ready must last exactly one cycle.");

    AST_READY_AFTER_SETUP: // see [R8]
    assert property (setup |=> PREADY_O)
    else $error("Ready must follow each setup cycle.");

    AST_ERROR_WITH_READY: // see [R8]
    assert property (PSLVERR_O |-> PREADY_O)
    else $error("Error answer seen without ready.");

    AST_READ_DATA: // see [R8]
    assert property (setup && hit |=>
        PRDATA_O[EN_BIT:GAIN_LO] == $past({st.cfg.en, st.cfg.gain}) &&
        PRDATA_O[NEG_BIT:POS_LO] == $past({st.cfg.neg, st.cfg.pos}))
    else $error("Read data does not match the stored fields.");

    AST_WRITE_LANE0: // see [R3] [R4]
    assert property (wr_hit && PSTRB_I[0] |=>
        st.cfg.neg == $past(PWDATA_I[NEG_BIT]) &&
        st.cfg.pos == $past(PWDATA_I[POS_HI:POS_LO]))
    else $error("Select lane was not stored.");

    AST_LANE1_KEPT: // see [R1] [R2]
    assert property (wr_hit && !PSTRB_I[1] |=>
        $stable(st.cfg.en) && $stable(st.cfg.gain))
    else $error("Enable and gain changed without their strobe.");

    AST_NO_WRITE_KEPT: // see [R8]
    assert property (!wr_hit |=> $stable(st.cfg))
    else $error("Register changed without a mapped write.");

    AST_ENABLE_LEVEL: // see [R1]
    assert property (STEP4_ENABLE_O == $past(st.cfg.en))
    else $error("Step enable does not track the stored bit.");

    AST_EXT_CLEAR_INTERNAL: // see [R5] [R6]
    assert property (st.cfg.pos > POS_EXT_LAST |=> STEP4_EXT_POS_O == 8'h00)
    else $error("No external input may be chosen for an internal source.");

    AST_NEG_EXCLUSIVE: // see [R3]
    assert property (!(STEP4_NEG_GND_O && STEP4_NEG_EXT7_O))
    else $error("Negative input may not be on ground and input seven.");

    AST_EXTERNAL_SINGLE: // see [R4]
    assert property (STEP4_SRC_O == SRC_EXTERNAL |-> $onehot(STEP4_EXT_POS_O))
    else $error("An external source needs exactly one external input.");

    // Main scenarios the bench should reach.
    COV_WRITE_HIT: cover property (wr_hit && PSTRB_I[1:0] == 2'b11);
    COV_READ_HIT: cover property (rd_hit);
    COV_LANE0_ONLY: cover property (wr_hit && PSTRB_I[1:0] == 2'b01);
    COV_UNMAPPED: cover property (access && PSLVERR_O);
    COV_INTERNAL_ENABLED: cover property (STEP4_ENABLE_O &&
        STEP4_NEG_AUTO_O && $past(st.cfg.neg));
endmodule

`default_nettype wire

//--- testbench/asq_step4_top_bench.sv
// Self-checking bench for the step 4 configuration register and its decode.
// Assumes an APB slave that may add wait states, and registered outputs.
`default_nettype none

module asq_step4_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import asq_pkg::*;

    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        step_en;
    logic [2:0]  step_gain;
    logic [7:0]  ext_pos;
    asq_src_t    src;
    logic        neg_auto;
    logic        neg_gnd;
    logic        neg_ext7;
    int          fails;
    int          compares;
    int          cycles = 0;

    asq_step4_top DUT (
        .REF_CLK_I       (clk),
        .RESETN_I        (rst_n),
        .PSEL_I          (psel),
        .PENABLE_I       (penable),
        .PWRITE_I        (pwrite),
        .PADDR_I         (paddr),
        .PWDATA_I        (pwdata),
        .PSTRB_I         (pstrb),
        .PRDATA_O        (prdata),
        .PREADY_O        (pready),
        .PSLVERR_O       (pslverr),
        .STEP4_ENABLE_O  (step_en),
        .STEP4_GAIN_O    (step_gain),
        .STEP4_EXT_POS_O (ext_pos),
        .STEP4_SRC_O     (src),
        .STEP4_NEG_AUTO_O(neg_auto),
        .STEP4_NEG_GND_O (neg_gnd),
        .STEP4_NEG_EXT7_O(neg_ext7)
    );

    // The clock is free running at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // A hung handshake would stall the run, so a cycle ceiling cuts it off.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high,
    // and only the bench timeout ends a wait that never closes.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Decoded outputs trail the register by a cycle, so let two edges pass.
    task automatic check_outputs(input logic [15:0] w);
        logic       auto;
        logic [2:0] g;
        logic [7:0] e;
        asq_src_t   s;
        auto = w[3];
        e = auto ? 8'h00 : 8'h01 << w[2:0];
        g = (w[14:13] == 2'h0) ? 3'h1 : (w[14:13] == 2'h1) ? 3'h2 : 3'h4;
        case (w[3:0])
            4'h8:    s = SRC_TEMP_SENSOR;
            4'h9:    s = SRC_INT_SHORT;
            4'ha:    s = SRC_TEST_DAC;
            4'hb:    s = SRC_ANALOG_SUPPLY_DIV4;
            4'hc:    s = SRC_IO_SUPPLY_MON;
            4'hd:    s = SRC_DCORE_SUPPLY_MON;
            4'he:    s = SRC_ANALOG_PWR_DIV103;
            4'hf:    s = SRC_DIGITAL_PWR_DIV103;
            default: s = SRC_EXTERNAL;
        endcase
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("enable", 32'(step_en), 32'(w[15]));
        check("gain", 32'(step_gain), 32'(g));
        check("ext_pos", 32'(ext_pos), 32'(e));
        check("source", 32'(src), 32'(s));
        check("neg_auto", 32'(neg_auto), 32'(auto));
        check("neg_gnd", 32'(neg_gnd), 32'(!auto && !w[4]));
        check("neg_ext7", 32'(neg_ext7), 32'(!auto && w[4]));
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, 12'h094, 32'h0, 4'h0, rd, err);
        check("reset_word", rd, 32'h0000_0004);
        check_outputs(16'h0004);
    endtask

    // Every positive code with both negative selects, all gain codes too.
    task automatic t_codes();
        logic [31:0] rd;
        logic [31:0] w;
        logic        err;
        for (int n = 0; n < 2; n++) begin
            for (int p = 0; p < 16; p++) begin
                w = {16'h0, n[0], p[1:0], 8'h00, n[0], p[3:0]};
                apb(1'b1, 12'h094, w, 4'hf, rd, err);
                check("write_err", 32'(err), 32'h0);
                apb(1'b0, 12'h094, 32'h0, 4'h0, rd, err);
                check("readback", rd, w);
                check_outputs(w[15:0]);
            end
        end
    endtask

    // Reserved bits stay zero; a partial strobe touches only its lane.
    task automatic t_reserved();
        logic [31:0] rd;
        logic        err;
        apb(1'b1, 12'h094, 32'hffff_ffff, 4'hf, rd, err);
        apb(1'b0, 12'h094, 32'h0, 4'h0, rd, err);
        check("reserved", rd, 32'h0000_e01f);
        apb(1'b1, 12'h094, 32'h0, 4'h1, rd, err);
        apb(1'b0, 12'h094, 32'h0, 4'h0, rd, err);
        check("lane0", rd, 32'h0000_e000);
        check_outputs(16'he000);
    endtask

    // Neighbouring addresses answer with an error and leave the word alone.
    task automatic t_unmapped();
        logic [31:0] rd;
        logic        err;
        apb(1'b1, 12'h098, 32'h0000_801f, 4'hf, rd, err);
        check("wr_err", 32'(err), 32'h1);
        apb(1'b0, 12'h095, 32'h0, 4'h0, rd, err);
        check("rd_err", 32'(err), 32'h1);
        check("rd_zero", rd, 32'h0);
        apb(1'b0, 12'h094, 32'h0, 4'h0, rd, err);
        check("kept", rd, 32'h0000_e000);
    endtask

    // Main sequence, with a second reset in mid-run.
    initial begin
        fails = 0;
        compares = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_codes();
        t_reserved();
        t_unmapped();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        complete_run();
    end
endmodule

`default_nettype wire
